// ==== rtl/sio_defs.vh ====
// Purpose: constants for the clocked synchronous serial interface
// Assumes: 8-bit register port, printed offsets used as addresses
// Notes:   see summary below
// Summary of operation
// [R1] status bit 7 reads 1 while a transfer operation is in progress
// [R2] status bit 6 reads 1 while the shift register is shifting
// [R3] status bit 5 sticky receive overrun flag, kept until cleared
// [R4] status bit 4 set when a byte was received since last buffer read
// [R5] status bit 3 sticky transmit underrun flag, kept until cleared
// [R6] status bit 2 shows transmit buffer holds untransmitted data
// [R7] reading status clears overrun and underrun flags
// [R8] reading the data buffer clears the receive-complete flag
// [R9] writing mode 00 clears all status bits, running or not
// [R10] deep halt or idle-zero entry forces mode 00 and clears status
// [R11] status bits 1 and 0 read 0; status read-only, resets to 0
// [R12] clock-gate enable 0 stops the interface; resets to 0
// [R13] software sets the clock-gate enable before touching control registers
// [R14] software never clears the clock-gate enable during a transfer
// [R15] bit-order 0 shifts LSB first, 1 shifts MSB first
// [R16] clock codes 000..110 generate the clock and drive the clock pin
// [R17] code 111 shifts on the external clock pin, which partner drives
// [R18] dividers 512..2 of gear clock; slow modes only code 110, fs/8
// [R19] edge select 0: launch on falling, sample on rising
// [R20] edge select 1: launch on rising, sample on falling
// [R21] partner leaves four gear clocks between byte's last and next edge
// [R22] mode 00 stop, 01 transmit, 10 receive, 11 both
// [R23] buffer read gives last received byte or 0; write loads transmit byte
// [R24] one 8-bit shift register, exactly eight bits per byte
`ifndef SIO_DEFS_VH
`define SIO_DEFS_VH

`define ADDR_CONTROL    12'h01f
`define ADDR_STATUS     12'h020
`define ADDR_DATA       12'h021
`define ADDR_POWER_GATE 12'hf76

`define CTL_EDGE  7
`define CTL_CKS_HI 6
`define CTL_CKS_LO 4
`define CTL_DIR   3
`define CTL_START 2

`define MODE_STOP 2'h0
`define MODE_TX   2'h1
`define MODE_RX   2'h2
`define MODE_TXRX 2'h3

`define CKS_EXT   3'h7
`define CKS_LOW   3'h6

// half period minus one, in gear clocks
`define HALF_512  8'hff
`define HALF_64   8'h1f
`define HALF_32   8'h0f
`define HALF_16   8'h07
`define HALF_8    8'h03
`define HALF_4    8'h01
`define HALF_2    8'h00
// half of fs/8, minus one, in low-frequency clock edges
`define HALF_FS   8'h03

`define BIT_LAST  3'h7
`define BYTE_ZERO 8'h00
`define SO_IDLE   1'b1

`endif

// ==== rtl/sync_serial_status_clocking.v ====
// Purpose: 8-bit clocked synchronous serial interface with status
// Assumes: gear clock is i_core_clk; pin inputs arrive asynchronously
// Notes:   registers on a plain strobe port, read data one cycle later
//
// The implementer's own choice: the strobed register port.
`include "sio_defs.vh"

module sync_serial_status_clocking (
	// clock and reset
	input  wire        i_core_clk,
	input  wire        i_reset_n,
	// register port
	input  wire [11:0] i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output wire [7:0]  o_rdata,
	// power mode control
	input  wire        i_halt_entry,
	input  wire        i_low_speed_mode,
	input  wire        i_low_freq_clk,
	// serial pins
	input  wire        i_sck,
	output wire        o_sck,
	output wire        o_sck_oe,
	input  wire        i_serial_in,
	output wire        o_serial_out
);

	reg        rst_a_q;
	reg        rst_n_q;
	reg  [7:0] rdata_q;
	reg        gate_en_q;
	reg        edge_q;
	reg  [2:0] cks_q;
	reg        dir_q;
	reg        start_q;
	reg  [1:0] mode_q;
	reg        active_q;
	reg        shift_q;
	reg        ovr_q;
	reg        rx_complete_flag_q;
	reg        unr_q;
	reg        full_q;
	reg        stop_pend_q;
	reg  [7:0] sr_q;
	reg  [7:0] tx_buf_q;
	reg  [7:0] rx_data_q;
	reg  [2:0] bit_q;
	reg        sck_q;
	reg        sck_oe_q;
	reg        so_q;
	reg  [7:0] div_q;
	reg  [2:0] sck_sync_q;
	reg  [2:0] si_sync_q;
	reg  [2:0] fs_sync_q;
	reg        sck_st_q;
	reg        sck_prev_q;
	reg        si_st_q;
	reg        fs_st_q;
	reg        fs_prev_q;

	// pin synchronisers; a change counts once stages two and three agree
	always @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sck_sync_q <= 3'h0;
			si_sync_q  <= 3'h0;
			fs_sync_q  <= 3'h0;
			sck_st_q   <= 1'b0;
			sck_prev_q <= 1'b0;
			si_st_q    <= 1'b0;
			fs_st_q    <= 1'b0;
			fs_prev_q  <= 1'b0;
		end else begin
			sck_sync_q <= {sck_sync_q[1:0], i_sck};
			si_sync_q  <= {si_sync_q[1:0], i_serial_in};
			fs_sync_q  <= {fs_sync_q[1:0], i_low_freq_clk};
			if (sck_sync_q[1] == sck_sync_q[2])
				sck_st_q <= sck_sync_q[2];
			if (si_sync_q[1] == si_sync_q[2])
				si_st_q <= si_sync_q[2];
			if (fs_sync_q[1] == fs_sync_q[2])
				fs_st_q <= fs_sync_q[2];
			sck_prev_q <= sck_st_q;
			fs_prev_q  <= fs_st_q;
		end
	end

	// reset release through two flops
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_a_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n_q <= rst_a_q;
		end
	end

	wire internal  = (cks_q != `CKS_EXT);
	wire tx_on     = mode_q[0];
	wire rx_on     = mode_q[1];
	wire sck_idle  = ~edge_q;
	wire ext_rise  = sck_st_q & ~sck_prev_q;
	wire ext_fall  = ~sck_st_q & sck_prev_q;
	wire fs_edge   = fs_st_q & ~fs_prev_q;

	// a read of a register is a side effect only when the interface is clocked
	wire wr_ctl  = i_wr & gate_en_q & (i_addr == `ADDR_CONTROL);
	wire wr_data = i_wr & gate_en_q & (i_addr == `ADDR_DATA);
	wire rd_stat = i_rd & gate_en_q & (i_addr == `ADDR_STATUS);
	wire rd_data = i_rd & gate_en_q & (i_addr == `ADDR_DATA);

	// divider: slow modes only run with code 110 on the low-frequency clock
	reg  [7:0] half;
	reg        div_step;
	always @* begin
		half     = `HALF_2;
		div_step = ~i_low_speed_mode;
		case (cks_q)
			3'h0: half = `HALF_512; // R18
			3'h1: half = `HALF_64;
			3'h2: half = `HALF_32;
			3'h3: half = `HALF_16;
			3'h4: half = `HALF_8;
			3'h5: half = `HALF_4;
			3'h6: begin
				half = i_low_speed_mode ? `HALF_FS : `HALF_2; // R18
				div_step = i_low_speed_mode ? fs_edge : 1'b1;
			end
			default: half = `HALF_2;
		endcase
	end

	wire int_run  = gate_en_q & shift_q & internal; // R12 R16
	wire int_tick = int_run & div_step & (div_q == half);

	// leading edge leaves the idle level and launches, trailing edge samples;
	// idle high for edge 0 gives falling launch, idle low for edge 1 rising
	wire int_launch = int_tick & (sck_q == sck_idle); // R19 R20
	wire int_sample = int_tick & (sck_q != sck_idle);
	wire ext_ok     = gate_en_q & active_q & ~internal; // R17
	wire ext_launch = ext_ok & (edge_q ? ext_rise : ext_fall); // R19 R20
	wire ext_sample = ext_ok & (edge_q ? ext_fall : ext_rise);
	wire launch     = int_launch | (ext_launch & shift_q);
	wire sample     = int_sample | (ext_sample & shift_q);
	wire done       = sample & (bit_q == `BIT_LAST); // R24

	wire       out_bit = dir_q ? sr_q[7] : sr_q[0]; // R15
	wire [7:0] sr_next = dir_q ? {sr_q[6:0], si_st_q} : {si_st_q, sr_q[7:1]}; // R15 R24

	// auto wait of the internal clock ends when data and buffer allow it
	wire can_go = active_q & internal & ~shift_q & ~stop_pend_q
		& (~tx_on | full_q) & (~rx_on | ~rx_complete_flag_q);
	wire ext_go = ext_ok & ~shift_q & tx_on & full_q;

	always @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_q     <= `BYTE_ZERO;
			gate_en_q   <= 1'b0; // R12
			edge_q      <= 1'b0;
			cks_q       <= 3'h0;
			dir_q       <= 1'b0;
			start_q     <= 1'b0;
			mode_q      <= `MODE_STOP;
			active_q    <= 1'b0; // R11
			shift_q     <= 1'b0;
			ovr_q       <= 1'b0;
			rx_complete_flag_q      <= 1'b0;
			unr_q       <= 1'b0;
			full_q      <= 1'b0;
			stop_pend_q <= 1'b0;
			sr_q        <= `BYTE_ZERO;
			tx_buf_q    <= `BYTE_ZERO;
			rx_data_q   <= `BYTE_ZERO; // R23
			bit_q       <= 3'h0;
			sck_q       <= 1'b1;
			sck_oe_q    <= 1'b0;
			so_q        <= `SO_IDLE;
			div_q       <= 8'h00;
		end else begin
			// register reads; status low bits read zero
			rdata_q <= `BYTE_ZERO;
			if (i_rd) begin
				case (i_addr)
					`ADDR_STATUS: if (gate_en_q)
						rdata_q <= {active_q, shift_q, ovr_q, rx_complete_flag_q, // R1 R2 R3 R4
							unr_q, full_q, 2'b00}; // R5 R6 R11
					`ADDR_DATA: if (gate_en_q)
						rdata_q <= rx_data_q; // R23
					`ADDR_CONTROL: if (gate_en_q)
						rdata_q <= {edge_q, cks_q, dir_q, start_q, mode_q};
					`ADDR_POWER_GATE: rdata_q <= {7'h00, gate_en_q};
					default: rdata_q <= `BYTE_ZERO;
				endcase
			end
			if (i_wr && i_addr == `ADDR_POWER_GATE)
				gate_en_q <= i_wdata[0]; // R12

			// divider and serial clock
			if (!int_run) begin
				div_q <= 8'h00;
			end else if (div_step) begin
				div_q <= (div_q == half) ? 8'h00 : div_q + 8'h01;
			end
			if (int_tick)
				sck_q <= ~sck_q;
			else if (!shift_q || !internal)
				sck_q <= sck_idle;
			sck_oe_q <= gate_en_q & internal & (mode_q != `MODE_STOP); // R16

			// flags cleared by reads; a set later in this block wins
			if (rd_stat) begin
				ovr_q <= 1'b0; // R7
				unr_q <= 1'b0; // R7
			end
			if (rd_data)
				rx_complete_flag_q <= 1'b0; // R8

			// shifting
			if (launch)
				so_q <= tx_on ? out_bit : `SO_IDLE;
			if (sample) begin
				sr_q  <= sr_next;
				bit_q <= bit_q + 3'h1;
			end
			if (ext_launch && !shift_q && tx_on)
				unr_q <= 1'b1; // R5
			if (done) begin
				bit_q <= 3'h0;
				if (rx_on) begin
					rx_data_q <= sr_next; // R23
					rx_complete_flag_q    <= 1'b1; // R4
					if (rx_complete_flag_q && !rd_data)
						ovr_q <= 1'b1; // R3
				end
				if (stop_pend_q) begin
					active_q    <= 1'b0;
					shift_q     <= 1'b0;
					full_q      <= 1'b0;
					start_q     <= 1'b0;
					stop_pend_q <= 1'b0;
					if (internal)
						so_q <= `SO_IDLE;
				end else if (tx_on && full_q) begin
					sr_q   <= tx_buf_q;
					full_q <= 1'b0; // R6
				end else if (internal || tx_on) begin
					shift_q <= 1'b0; // R2
					if (internal)
						so_q <= `SO_IDLE;
				end
			end else if (can_go || ext_go) begin
				shift_q <= 1'b1; // R2
				if (tx_on) begin
					sr_q   <= tx_buf_q;
					full_q <= 1'b0;
				end
			end

			// buffer write: queue while a byte is in the shifter
			if (wr_data) begin
				tx_buf_q <= i_wdata; // R23
				if (active_q && tx_on)
					full_q <= 1'b1; // R6
			end

			// control write
			if (wr_ctl) begin
				if (!active_q) begin
					edge_q <= i_wdata[`CTL_EDGE];
					cks_q  <= i_wdata[`CTL_CKS_HI:`CTL_CKS_LO];
					dir_q  <= i_wdata[`CTL_DIR];
					mode_q <= i_wdata[1:0]; // R22
					if (i_wdata[`CTL_START] && i_wdata[1:0] != `MODE_STOP) begin
						start_q  <= 1'b1;
						active_q <= 1'b1; // R1
						shift_q  <= 1'b1; // R2
						sr_q     <= tx_buf_q; // R24
						bit_q    <= 3'h0;
					end
				end else if (!i_wdata[`CTL_START] && start_q) begin
					if (!shift_q) begin
						active_q <= 1'b0;
						full_q   <= 1'b0;
						start_q  <= 1'b0;
						if (internal)
							so_q <= `SO_IDLE;
					end else begin
						stop_pend_q <= 1'b1;
						start_q     <= 1'b0;
					end
				end
			end

			// forced stop by mode 00 or low power entry clears all status
			if ((wr_ctl && i_wdata[1:0] == `MODE_STOP) || i_halt_entry) begin
				mode_q      <= `MODE_STOP; // R9 R10 R22
				start_q     <= 1'b0;
				active_q    <= 1'b0;
				shift_q     <= 1'b0;
				ovr_q       <= 1'b0;
				rx_complete_flag_q      <= 1'b0;
				unr_q       <= 1'b0;
				full_q      <= 1'b0;
				stop_pend_q <= 1'b0;
				bit_q       <= 3'h0;
				so_q        <= `SO_IDLE;
				sck_q       <= 1'b1;
			end
		end
	end

	assign o_rdata      = rdata_q;
	assign o_sck        = sck_q;
	assign o_sck_oe     = sck_oe_q;
	assign o_serial_out = so_q;

endmodule

// ==== sim/sync_serial_status_clocking_properties.sv ====
// Purpose: port checks for the serial status block
// Assumes: one core clock domain
// Notes:   bound to the block below
module sio_checker (
	input wire        i_core_clk,
	input wire        i_reset_n,
	input wire [11:0] i_addr,
	input wire [7:0]  i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire        i_halt_entry,
	input wire [7:0]  o_rdata,
	input wire        o_sck_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic gate_q;
	wire  sr = i_rd && i_addr == 12'h020;
	wire  dr = i_rd && i_addr == 12'h021;
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			gate_q <= 1'b0;
		else if (i_wr && i_addr == 12'hf76)
			gate_q <= i_wdata[0];
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	quiet_port_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("stray read data");
	low_bits_a: assert property ($past(sr) |-> o_rdata[1:0] == 2'h0)
		else $error("status low bits set");
	flag_nest_a: assert property ($past(sr) && o_rdata[6] |-> o_rdata[7])
		else $error("shifting while idle");
	stop_clear_a: assert property (
		i_wr && i_addr == 12'h01f && i_wdata[1:0] == 2'h0 ##1 !i_wr ##1 sr |=> o_rdata == 8'h00)
		else $error("status kept after stop");
	halt_clear_a: assert property (i_halt_entry ##1 !i_wr ##1 sr |=> o_rdata == 8'h00)
		else $error("status kept after halt");
	err_clear_a: assert property (
		sr && o_sck_oe ##1 !i_wr ##1 sr && o_sck_oe |=> (o_rdata & 8'h28) == 8'h00)
		else $error("error flag kept");
	rx_complete_flag_clear_a: assert property (dr && o_sck_oe ##1 !i_wr ##1 sr |=> !o_rdata[4])
		else $error("receive flag kept");
	gate_pin_a: assert property (!gate_q && !$past(gate_q) |-> !o_sck_oe)
		else $error("clock pin driven, gate off");
	gate_read_a: assert property ($past(i_rd) && !$past(gate_q) |-> o_rdata == 8'h00)
		else $error("read data, gate off");
endmodule
bind sync_serial_status_clocking sio_checker chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_halt_entry(i_halt_entry),
	.o_rdata(o_rdata), .o_sck_oe(o_sck_oe));

// ==== sim/serial_peer.sv ====
// Purpose: far-side serial device
// Assumes: the block makes the serial clock unless ext is high
// Notes:   data line toggles outside frames
module serial_peer (
	input  wire logic       clk,
	input  wire logic       ext,
	input  wire logic       sck,
	input  wire logic       oe,
	input  wire logic       so,
	input  wire logic       edg,
	input  wire logic       msb,
	input  wire logic [7:0] tx,
	output logic            si,
	output logic            ext_sck,
	output logic [7:0]      rx
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	initial begin
		si = 1'b0;
		ext_sck = 1'b1;
		n = 0;
	end
	// with ext high the peer owns the clock pin and frames on its own clock
	wire lk = ext ? ext_sck : sck;
	wire on = oe | ext;
	always @(posedge clk) begin
		if (!on) begin
			n <= 0;
			si <= ~si;
		end
	end
	// one byte of external clock, idle high, then the gap before the next byte
	task automatic run_ext();
		repeat (8) begin
			repeat (8) @(posedge clk);
			ext_sck <= 1'b0;
			repeat (8) @(posedge clk);
			ext_sck <= 1'b1;
		end
		repeat (8) @(posedge clk);
	endtask
	always @(lk) begin
		if (on && (lk ^ edg))
			rx <= msb ? {rx[6:0], so} : {so, rx[7:1]};
		else if (on) begin
			si <= tx[msb ? 7 - n : n];
			n <= n + 1;
		end
	end
endmodule

// ==== sim/sync_serial_status_clocking_bench.sv ====
// Purpose: self-checking bench for the serial status block
// Assumes: internal clock loop, then one external clock transmit
// Notes:   peer answers on the serial pins
module sync_serial_status_clocking_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_core_clk, i_reset_n, i_wr, i_rd, i_halt_entry, edg, msb;
	logic        o_sck, o_sck_oe, o_serial_out, si, xsck, pext;
	logic [11:0] i_addr;
	logic [7:0]  i_wdata, o_rdata, v, ptx, prx;
	logic [31:0] seed;
	logic [7:0]  exp_q[$];
	int          bad_count, n_compared, k;
	sync_serial_status_clocking u_sync_serial_status_clocking (.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_halt_entry(i_halt_entry), .i_low_speed_mode(1'b0),
		.i_low_freq_clk(1'b0), .i_sck(xsck), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
		.i_serial_in(si), .o_serial_out(o_serial_out));
	serial_peer u_serial_peer (.clk(i_core_clk), .ext(pext), .sck(o_sck), .oe(o_sck_oe),
		.so(o_serial_out),
		.edg(edg), .msb(msb), .tx(ptx), .si(si), .ext_sck(xsck), .rx(prx));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	task automatic results;
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	// three short transfers take under a thousand cycles, far inside the 50000-cycle limit
	initial begin
		#2000000;
		bad_count++;
		results();
	end
	initial begin
		{i_reset_n, i_wr, i_rd, i_halt_entry, edg, msb} = 6'h00;
		i_addr = 12'h000;
		i_wdata = 8'h00;
		ptx = 8'h00;
		pext = 1'b0;
		seed = 32'h1d63;
		bad_count = 0;
		n_compared = 0;
		repeat (2) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		rd(12'h020);
		check(v, 8'h00);
		wr(12'h021, 8'h5a);
		rd(12'h020);
		check(v, 8'h00);
		wr(12'hf76, 8'h01);
		rd(12'h021);
		check(v, 8'h00);
		rd(12'h123);
		check(v, 8'h00);
		for (k = 0; k < 3; k++) begin
			edg = k[0];
			msb = k[0];
			seed = lfsr(seed);
			ptx = seed[15:8];
			// configure while stopped so the idle level settles first
			wr(12'h01f, {edg, 3'h2, msb, 3'h0});
			wr(12'h021, seed[7:0]);
			wr(12'h01f, {edg, 3'h2, msb, 3'h7});
			if (k == 2) begin
				rd(12'h020);
				check(v, 8'hc0);
				@(posedge i_core_clk);
				i_halt_entry <= 1'b1;
				@(posedge i_core_clk);
				i_halt_entry <= 1'b0;
				rd(12'h020);
				check(v, 8'h00);
			end else begin
				exp_q.push_back(seed[7:0]);
				v = 8'h40;
				for (int t = 0; t < 400 && v[6]; t++)
					rd(12'h020);
				rd(12'h020);
				check(v, 8'h90);
				wr(12'h01f, {edg, 3'h2, msb, 3'h3});
				rd(12'h020);
				check(v, 8'h10);
				if (k == 0) begin
					wr(12'h01f, 8'h00);
					rd(12'h020);
					check(v, 8'h00);
				end
				rd(12'h021);
				check(v, ptx);
				rd(12'h020);
				check(v, 8'h00);
				check(prx, exp_q.pop_front());
			end
		end
		// external clock transmit, msb first, then an underrun byte
		edg = 1'b0;
		msb = 1'b1;
		pext = 1'b1;
		seed = lfsr(seed);
		wr(12'h01f, 8'h78);
		wr(12'h021, seed[7:0]);
		wr(12'h01f, 8'h7d);
		exp_q.push_back(seed[7:0]);
		u_serial_peer.run_ext();
		rd(12'h020);
		check(v, 8'h80);
		check(prx, exp_q.pop_front());
		u_serial_peer.run_ext();
		rd(12'h020);
		check(v, 8'h88);
		rd(12'h020);
		check(v, 8'h80);
		wr(12'h01f, 8'h00);
		rd(12'h020);
		check(v, 8'h00);
		pext = 1'b0;
		results();
	end
endmodule
